/* File: tpc_cfg.svh */
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH
// ============================================================
// Register offsets
`define TPC_OFS_CTRL 12'h000
`define TPC_OFS_STAT 12'h004
`define TPC_OFS_ISTS 12'h008
`define TPC_OFS_IMSK 12'h00c
// ============================================================
// Control register fields
`define TPC_B_ENC    0
`define TPC_B_LOWLAT 1
`define TPC_B_TXFLIP 2
`define TPC_B_RXFLIP 3
`define TPC_B_TXREV  4
`define TPC_B_DBL    5
`define TPC_B_RXREV  6
`define TPC_B_TXSHR  7
`define TPC_F_OPM    9:8
// ============================================================
// Interrupt status fields
`define TPC_B_IERR   0
`define TPC_B_IDISP  1
// ============================================================
// Reset values
`define TPC_CTRL_RST 32'h0000_0001
`define TPC_IMSK_RST 2'h0
// ============================================================
// Bus responses and fixed code groups
`define TPC_RESP_OK  2'h0
`define TPC_RESP_ERR 2'h2
`define TPC_K28_6B   6'h0f
`define TPC_A7_4B    4'h7
`endif

/* File: tpc_pkg.sv */
package tpc_pkg;
  // Operation modes of the channel
  typedef enum logic [1:0] {
    TPC_DUPLEX  = 2'h0,
    TPC_TX_ONLY = 2'h1,
    TPC_RX_ONLY = 2'h2
  } tpc_opmode_t;
endpackage

/* File: tpc_pcs.sv */
// Added by the designer: the AXI4-Lite register port and the register addresses.
`include "tpc_cfg.svh"
// Operation
// RULE1: Low latency bypasses all coding sublayer functions; the transmit and receive byte flips still apply
// RULE2: Coder allowed only at 8/16/32 bit width
// RULE3: Forced disparity uses the disparity-value input
// RULE4: Otherwise normal running disparity selects code groups
// RULE5: Control detect high for twelve control groups
// RULE6: Control detect low for data groups
// RULE7: Status outputs one bit per decoded byte
// RULE8: Code error on violation or disparity error
// RULE9: Disparity error also raises code error
// RULE10: Running disparity output per decoded byte
// RULE11: Receive flip reverses bits within bytes
// RULE12: Transmit flip reverses bits within bytes
// RULE13: Single-width reversal mirrors 8/10-bit serializer word
// RULE14: Double-width reversal mirrors 16/20-bit serializer word
// RULE15: Polarity input inverts every serializer bit
// RULE16: Receive reversal input mirrors aligner output
// RULE17: Slip select sets slipped bits, transmit modes
// RULE18: Transmit core clock shared or per channel
// RULE19: Decoder status registered with its byte
module tpc_pcs #(
  parameter int CH_W = 16, // Fabric channel width
  parameter int AW   = 12  // Register address width
) (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // Register bus
  input  wire logic [AW-1:0]          s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output wire logic                   s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output wire logic                   s_axi_wready,
  output logic      [1:0]             s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [AW-1:0]          s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output wire logic                   s_axi_arready,
  output logic      [31:0]            s_axi_rdata,
  output logic      [1:0]             s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Transmit fabric side
  input  wire logic [CH_W-1:0]        tx_data,
  input  wire logic [CH_W/8-1:0]      tx_ctrl,
  input  wire logic [CH_W/8-1:0]      tx_forcedisp,
  input  wire logic [CH_W/8-1:0]      tx_dispval,
  input  wire logic                   tx_invpolarity,
  input  wire logic [4:0]             tx_slipsel,
  // Serializer side
  output logic      [CH_W/8*10-1:0]   ser_data,
  // Deserializer side
  input  wire logic [CH_W/8*10-1:0]   des_data,
  input  wire logic                   rx_revbitorder,
  // Receive fabric side
  output logic      [CH_W-1:0]        rx_data,
  output logic      [CH_W/8-1:0]      rx_ctrldetect,
  output logic      [CH_W/8-1:0]      rx_errdetect,
  output logic      [CH_W/8-1:0]      rx_disperr,
  output logic      [CH_W/8-1:0]      rx_runningdisp,
  // Clocking choice and interrupt
  output logic                        tx_clk_shared,
  output wire logic                   irq
);
  // ==========================================================
  // Geometry and code tables
  localparam int NB = CH_W/8;                           // Bytes per word
  localparam int TW = 10*NB;                            // Serial word width
  localparam int G2 = (NB % 2 == 0) ? 2 : 1;            // Lanes in a double word
  localparam bit WIDTH_OK = (CH_W == 8) || (CH_W == 16) || (CH_W == 32);
  localparam logic [5:0] T6 [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
                                     6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
                                     6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
                                     6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] T4 [8]  = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

  // ==========================================================
  // Functions
  // Count of ones in a code group
  function automatic logic [3:0] ones(input logic [9:0] v);
    ones = 4'h0;
    for (int i = 0; i < 10; i++) ones = ones + {3'h0, v[i]};
  endfunction

  // One byte to ten bits; returns {rd_out, code}
  function automatic logic [10:0] enc8(input logic [7:0] d, input logic k, input logic rd);
    logic [5:0] b6;
    logic [3:0] b4;
    logic       k28, u6, u4, rdm, alt;
    k28 = k && (d[4:0] == 5'h1c);
    b6  = k28 ? `TPC_K28_6B : T6[d[4:0]];
    u6  = ones({4'h0, b6}) != 4'h3;
    rdm = rd ^ u6;
    if (rd && (u6 || d[4:0] == 5'h07)) b6 = ~b6;
    alt = (d[7:5] == 3'h7) && (k || (!rdm && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14))
          || (rdm && (d[4:0] == 5'h0b || d[4:0] == 5'h0d || d[4:0] == 5'h0e)));
    b4  = alt ? `TPC_A7_4B : T4[d[7:5]];
    u4  = ones({6'h0, b4}) != 4'h2;
    if (rdm ? (u4 || d[7:5] == 3'h3) : (k28 && !u4 && d[7:5] != 3'h3)) b4 = ~b4;
    return {rdm ^ u4, b6, b4};
  endfunction

  // Ten bits to one byte; returns {rd_out, ctrl, code_err, disp_err, byte}
  function automatic logic [11:0] dec10(input logic [9:0] c, input logic rd);
    logic [5:0] b6;
    logic [3:0] b4, n6, n4;
    logic [4:0] x;
    logic [2:0] y;
    logic       f6, f4, k28, a7, rdm, de, kk, ce;
    b6  = c[9:4];
    b4  = c[3:0];
    n6  = ones({4'h0, b6});
    n4  = ones({6'h0, b4});
    x   = 5'h00;
    y   = 3'h0;
    f6  = 1'b0;
    f4  = 1'b0;
    a7  = 1'b0;
    k28 = (b6 == `TPC_K28_6B) || (b6 == ~`TPC_K28_6B);
    for (int i = 0; i < 32; i++) begin
      if (T6[i] == b6 || (T6[i] == ~b6 && (n6 != 4'h3 || i == 7))) begin
        x  = 5'(i);
        f6 = 1'b1;
      end
    end
    if (k28) begin
      x  = 5'h1c;
      f6 = 1'b1;
    end
    rdm = (n6 == 4'h3) ? rd : (n6 > 4'h3);
    de  = (n6 == 4'h4 && rd) || (n6 == 4'h2 && !rd) || (b6 == 6'h38 && rd) || (b6 == 6'h07 && !rd);
    // K28 after a negative six-bit half carries its four bits inverted
    if (k28 && b6 == ~`TPC_K28_6B) b4 = ~b4;
    for (int j = 0; j < 8; j++) begin
      if (T4[j] == b4 || (T4[j] == ~b4 && (n4 != 4'h2 || j == 3))) begin
        y  = 3'(j);
        f4 = 1'b1;
      end
    end
    if (b4 == `TPC_A7_4B || b4 == ~`TPC_A7_4B) begin
      y  = 3'h7;
      f4 = 1'b1;
      a7 = 1'b1;
    end
    de = de || (n4 == 4'h3 && rdm) || (n4 == 4'h1 && !rdm) || (c[3:0] == 4'hc && rdm) || (c[3:0] == 4'h3 && !rdm);
    kk = k28 || (a7 && (x == 5'h17 || x == 5'h1b || x == 5'h1d || x == 5'h1e));           // [RULE5]
    ce = !f6 || !f4 || de || (a7 && !kk && !(x == 5'h0b || x == 5'h0d || x == 5'h0e
         || x == 5'h11 || x == 5'h12 || x == 5'h14));                                     // [RULE8] [RULE9]
    return {(n4 == 4'h2) ? rdm : (n4 > 4'h2), kk, ce, de, y, x};
  endfunction

  // Mirror each group of g lanes over w active bits per lane
  function automatic logic [TW-1:0] mirror(input logic [TW-1:0] v, input int w, input int g);
    int s;
    mirror = v;
    for (int j = 0; j < NB*w; j++) begin
      s = (j/(g*w))*(g*w) + g*w - 1 - j%(g*w);
      mirror[(j/w)*10 + j%w] = v[(s/w)*10 + s%w];
    end
  endfunction

  // Word reversal for single or double width, coded or raw lanes
  function automatic logic [TW-1:0] rev_any(input logic [TW-1:0] v, input logic ten, input logic dbl);
    if (ten) rev_any = dbl ? mirror(v, 10, G2) : mirror(v, 10, 1);                    // [RULE13] [RULE14]
    else     rev_any = dbl ? mirror(v, 8, G2) : mirror(v, 8, 1);
  endfunction

  // Bit order reversed inside every byte
  function automatic logic [CH_W-1:0] byte_flip(input logic [CH_W-1:0] v);
    for (int i = 0; i < CH_W; i++) byte_flip[i] = v[(i/8)*8 + 7 - i%8];
  endfunction

  // ==========================================================
  // Registers and configuration
  logic [31:0]       ctrl_r;        // Control register
  logic [1:0]        ists_r;        // Sticky event bits
  logic [1:0]        imsk_r;        // Event mask
  logic              enc_act;       // Coder in use
  logic              lowlat;        // Bypass path
  tpc_pkg::tpc_opmode_t opm;        // Operation mode
  logic              aw_held_r;     // Write address held
  logic              w_held_r;      // Write data held
  logic [AW-1:0]     awaddr_r;      // Held write address
  logic [31:0]       wdata_r;       // Held write data
  logic [3:0]        wstrb_r;       // Held byte enables
  logic              wr_go;         // Write executes
  logic              wr_hit;        // Write address mapped
  logic [31:0]       stat_w;        // Live status word

  assign lowlat  = ctrl_r[`TPC_B_LOWLAT];
  assign opm     = tpc_pkg::tpc_opmode_t'(ctrl_r[`TPC_F_OPM]);
  assign enc_act = ctrl_r[`TPC_B_ENC] && !lowlat && WIDTH_OK;                            // [RULE1] [RULE2]
  assign irq     = |(ists_r & imsk_r);

  // ==========================================================
  // Transmit path
  logic [CH_W-1:0]   tx_fifo_r;     // Phase-compensation stage
  logic [NB-1:0]     tx_k_r;        // Control flags
  logic [NB-1:0]     tx_fd_r;       // Force flags
  logic [NB-1:0]     tx_dv_r;       // Forced disparity values
  logic              tx_inv_r;      // Polarity request
  logic              tx_rd_r;       // Encoder running disparity
  logic              tx_rd_nxt;     // Disparity after this word
  logic [TW-1:0]     enc_w;         // Coded or raw lanes
  logic [TW-1:0]     tx_prev_r;     // Previous word for slipping
  logic [TW-1:0]     tx_fin;        // Word toward serializer
  int                slip_n;        // Slipped bits

  // Input stage with byte flip ahead of the FIFO
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_fifo_r <= '0;
      tx_k_r    <= '0;
      tx_fd_r   <= '0;
      tx_dv_r   <= '0;
      tx_inv_r  <= 1'b0;
    end else begin
      tx_fifo_r <= ctrl_r[`TPC_B_TXFLIP] ? byte_flip(tx_data) : tx_data;                   // [RULE12]
      tx_k_r    <= tx_ctrl;
      tx_fd_r   <= tx_forcedisp;
      tx_dv_r   <= tx_dispval;
      tx_inv_r  <= tx_invpolarity;
    end
  end

  // Encoder, disparity chained byte 0 upward
  always_comb begin
    logic [10:0] e;
    logic        rd_v;
    e     = '0;
    rd_v  = tx_rd_r;
    enc_w = '0;
    for (int i = 0; i < NB; i++) begin
      e    = enc8(tx_fifo_r[8*i +: 8], tx_k_r[i], tx_fd_r[i] ? tx_dv_r[i] : rd_v);    // [RULE3] [RULE4]
      rd_v = e[10];
      enc_w[10*i +: 10] = enc_act ? e[9:0] : {2'h0, tx_fifo_r[8*i +: 8]};
    end
    tx_rd_nxt = enc_act ? rd_v : tx_rd_r;
  end

  // Slip, reversal and polarity toward the serializer
  always_comb begin
    logic [2*TW-1:0] sh;
    logic [TW-1:0]   rv;
    slip_n = (opm == tpc_pkg::TPC_RX_ONLY) ? 0 : int'(tx_slipsel) % TW;                  // [RULE17]
    sh     = {enc_w, tx_prev_r} >> (TW - slip_n);
    rv     = ctrl_r[`TPC_B_TXREV] ? rev_any(sh[TW-1:0], enc_act, ctrl_r[`TPC_B_DBL]) : sh[TW-1:0];
    tx_fin = tx_inv_r ? ~rv : rv;                                                          // [RULE15]
  end

  // Serializer word register, bypass in low latency
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser_data  <= '0;
      tx_prev_r <= '0;
      tx_rd_r   <= 1'b0;
    end else begin
      ser_data  <= lowlat ? enc_w : tx_fin;                                                // [RULE1]
      tx_prev_r <= enc_w;
      tx_rd_r   <= tx_rd_nxt;
    end
  end

  // ==========================================================
  // Receive path
  logic              rx_rd_r;       // Decoder running disparity
  logic              rx_rd_nxt;     // Disparity after this word
  logic [CH_W-1:0]   rx_byte;       // Decoded or raw bytes
  logic [NB-1:0]     ctl_nxt;       // Control per byte
  logic [NB-1:0]     err_nxt;       // Code error per byte
  logic [NB-1:0]     dsp_nxt;       // Disparity error per byte
  logic [NB-1:0]     rdb_nxt;       // Disparity per byte

  // Optional reversal, then decoder
  always_comb begin
    logic [TW-1:0] al;
    logic [11:0]   dd;
    logic          rd_v;
    al      = (ctrl_r[`TPC_B_RXREV] && rx_revbitorder && !lowlat)
              ? rev_any(des_data, enc_act, ctrl_r[`TPC_B_DBL]) : des_data;                  // [RULE16]
    dd      = '0;
    rd_v    = rx_rd_r;
    rx_byte = '0;
    ctl_nxt = '0;
    err_nxt = '0;
    dsp_nxt = '0;
    rdb_nxt = '0;
    for (int i = 0; i < NB; i++) begin
      dd   = dec10(al[10*i +: 10], rd_v);
      rd_v = dd[11];
      rx_byte[8*i +: 8] = enc_act ? dd[7:0] : al[10*i +: 8];
      ctl_nxt[i] = enc_act && dd[10];                                                      // [RULE5] [RULE6] [RULE7]
      err_nxt[i] = enc_act && dd[9];                                                       // [RULE8]
      dsp_nxt[i] = enc_act && dd[8];                                                       // [RULE9]
      rdb_nxt[i] = enc_act && rd_v;                                                        // [RULE10]
    end
    rx_rd_nxt = enc_act ? rd_v : rx_rd_r;
  end

  // Output stage: data and status leave together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data        <= '0;
      rx_ctrldetect  <= '0;
      rx_errdetect   <= '0;
      rx_disperr     <= '0;
      rx_runningdisp <= '0;
      rx_rd_r        <= 1'b0;
    end else begin
      rx_data        <= ctrl_r[`TPC_B_RXFLIP] ? byte_flip(rx_byte) : rx_byte;            // [RULE11]
      rx_ctrldetect  <= ctl_nxt;                                                           // [RULE19]
      rx_errdetect   <= err_nxt;
      rx_disperr     <= dsp_nxt;
      rx_runningdisp <= rdb_nxt;
      rx_rd_r        <= rx_rd_nxt;
    end
  end

  // ==========================================================
  // Register bus slave
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go  = aw_held_r && w_held_r;
  assign wr_hit = awaddr_r == `TPC_OFS_CTRL || awaddr_r == `TPC_OFS_ISTS || awaddr_r == `TPC_OFS_IMSK;
  assign stat_w = {28'h0, WIDTH_OK, tx_rd_r, rx_rd_r, enc_act};

  // Address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= {s_axi_awaddr[AW-1:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TPC_RESP_OK;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `TPC_RESP_OK : `TPC_RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control and mask registers, byte enables honoured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `TPC_CTRL_RST;
      imsk_r <= `TPC_IMSK_RST;
    end else if (wr_go) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_r[b] && awaddr_r == `TPC_OFS_CTRL) ctrl_r[8*b +: 8] <= wdata_r[8*b +: 8];
      end
      if (wstrb_r[0] && awaddr_r == `TPC_OFS_IMSK) imsk_r <= wdata_r[1:0];
    end
  end

  // Sticky events, a new event beats a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ists_r <= '0;
    end else begin
      ists_r <= (ists_r & ~((wr_go && wstrb_r[0] && awaddr_r == `TPC_OFS_ISTS) ? wdata_r[1:0] : 2'h0))
                | {|dsp_nxt, |err_nxt};
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `TPC_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `TPC_RESP_OK;
      unique case ({s_axi_araddr[AW-1:2], 2'h0})
        `TPC_OFS_CTRL: s_axi_rdata <= ctrl_r;
        `TPC_OFS_STAT: s_axi_rdata <= stat_w;
        `TPC_OFS_ISTS: s_axi_rdata <= {30'h0, ists_r};
        `TPC_OFS_IMSK: s_axi_rdata <= {30'h0, imsk_r};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= `TPC_RESP_ERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Transmit clock sharing choice
  always_ff @(posedge aclk) begin
    if (!aresetn) tx_clk_shared <= 1'b0;
    else          tx_clk_shared <= ctrl_r[`TPC_B_TXSHR];                                   // [RULE18]
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_tx_plain;
    enc_act && !ctrl_r[`TPC_B_TXREV] && !tx_inv_r && tx_slipsel == 5'h00 && !tx_k_r[0] && tx_fifo_r[7:0] == 8'h00;
  endsequence
  sequence s_aw_w;
    s_axi_awvalid && s_axi_awready ##0 s_axi_wvalid && s_axi_wready;
  endsequence

  AST_LOWLAT: assert property (lowlat |=> ser_data[7:0] == $past(tx_fifo_r[7:0]))  // [RULE1]
    else $error("low latency word not passed raw");
  AST_WIDTH: assert property (enc_act |-> WIDTH_OK)  // [RULE2]
    else $error("coder active at illegal width");
  AST_FORCE: assert property (s_tx_plain ##0 tx_fd_r[0] && tx_dv_r[0] |=> ser_data[9:4] == 6'h18)  // [RULE3]
    else $error("forced positive disparity not used");
  AST_NORMAL: assert property (s_tx_plain ##0 !tx_fd_r[0] && !tx_rd_r |=> ser_data[9:4] == 6'h27)  // [RULE4]
    else $error("negative running disparity code wrong");
  AST_CTRL: assert property (enc_act && !ctrl_r[`TPC_B_RXREV] && des_data[9:0] == 10'h0fa |=> rx_ctrldetect[0])  // [RULE5]
    else $error("control group not flagged");
  AST_DATA: assert property (enc_act && !ctrl_r[`TPC_B_RXREV] && des_data[9:0] == 10'h274 |=> !rx_ctrldetect[0])  // [RULE6]
    else $error("data group flagged as control");
  AST_CERR: assert property (enc_act && des_data[9:0] == 10'h3ff |=> rx_errdetect[0])  // [RULE8]
    else $error("invalid group not flagged");
  AST_DISP: assert property (rx_disperr[0] |-> rx_errdetect[0])  // [RULE9]
    else $error("disparity error without code error");
  AST_RXFLIP: assert property (lowlat && ctrl_r[`TPC_B_RXFLIP] |=> rx_data[0] == $past(des_data[7]) && rx_data[7] == $past(des_data[0]))  // [RULE11]
    else $error("receive byte flip wrong");
  AST_INV: assert property (!enc_act && !lowlat && !ctrl_r[`TPC_B_TXREV] && tx_slipsel == 5'h00 && tx_inv_r
                            |=> ser_data[7:0] == ~$past(tx_fifo_r[7:0]))  // [RULE15]
    else $error("polarity inversion missing");
  AST_IRQ: assert property (rx_errdetect[0] && imsk_r[`TPC_B_IERR] |-> irq)
    else $error("unmasked error gave no interrupt");
  AST_BRESP: assert property (s_aw_w |=> ##1 s_axi_bvalid)
    else $error("write response late");
endmodule

/* File: tpc_lnk_model.sv */
module tpc_lnk_model (
  // Serializer word in, aligner word out
  input  wire logic [19:0] ser_data,
  output logic      [19:0] des_data,
  // Forced word from the bench, for decoder, reversal and error cases
  input  wire logic        inj_en,
  input  wire logic [19:0] inj_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // Serial loop
  // Wire loopback; a forced word replaces it only on command
  always_comb begin
    des_data = inj_en ? inj_word : ser_data;
  end
endmodule

/* File: tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int due; bit sel; logic [31:0] m; logic [31:0] e;} tpc_exp_t;
  // ============================================================
  // Bench signals, named as the ports
  logic        aclk = 1'b0, aresetn = 1'b0, irq, tx_clk_shared, inj_en = 1'b0, rx_revbitorder = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_arready, s_axi_bvalid, s_axi_rvalid, tx_invpolarity = 1'b0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, seen;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rx_ctrldetect, rx_errdetect, rx_disperr, rx_runningdisp;
  logic [1:0]  tx_ctrl = '0, tx_forcedisp = '0, tx_dispval = '0;
  logic [15:0] tx_data = '0, rx_data, st = 16'h003d;
  logic [4:0]  tx_slipsel = '0;
  logic [19:0] ser_data, des_data, inj_word = '0;
  int          err_total = 0, n_checks = 0, cyc = 0;
  tpc_exp_t    q[$];
  // ============================================================
  // Design and far side
  tpc_pcs #(.CH_W(16), .AW(12)) tpc_pcs_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .tx_data, .tx_ctrl, .tx_forcedisp, .tx_dispval, .tx_invpolarity, .tx_slipsel, .ser_data, .des_data,
    .rx_revbitorder, .rx_data, .rx_ctrldetect, .rx_errdetect, .rx_disperr, .rx_runningdisp, .tx_clk_shared, .irq);
  tpc_lnk_model tpc_lnk_model_inst (.ser_data, .des_data, .inj_en, .inj_word);
  always #5 aclk = ~aclk;
  // ============================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Note a result due d edges after the last drive
  task automatic ex(input int d, input bit s, input logic [31:0] m, input logic [31:0] e);
    q.push_back('{cyc + d, s, m, e});
  endtask
  // AXI4-Lite write; address and data released as each is taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    bit ta = 1'b0;
    bit tw = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) ta = 1'b1;
      if (s_axi_wready === 1'b1) tw = 1'b1;
      s_axi_awvalid <= !ta;
      s_axi_wvalid <= !tw;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    chk({30'h0, s_axi_bresp}, {30'h0, r});
    s_axi_bready <= 1'b0;
  endtask
  // AXI4-Lite read, compared under a mask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    chk(s_axi_rdata & m, e);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
    s_axi_rready <= 1'b0;
  endtask
  // One fabric word, then a settle step so the note sees the new cycle count
  task automatic snd(input logic [15:0] d, input logic [1:0] k, fd, dv, input logic ip);
    @(posedge aclk);
    tx_data <= d;
    tx_ctrl <= k;
    tx_forcedisp <= fd;
    tx_dispval <= dv;
    tx_invpolarity <= ip;
    #1;
  endtask
  task automatic inj(input logic [19:0] w);
    @(posedge aclk);
    inj_word <= w;
    inj_en <= 1'b1;
    #1;
  endtask
  // ============================================================
  // Monitor: oldest note compared when its cycle comes
  always @(posedge aclk) begin
    cyc++;
    #2;
    while (q.size() > 0 && q[0].due <= cyc) begin
      seen = q[0].sel ? {8'h0, rx_runningdisp, rx_disperr, rx_errdetect, rx_ctrldetect, rx_data} : {12'h0, ser_data};
      chk(seen & q[0].m, q[0].e);
      void'(q.pop_front());
    end
  end
  // Watchdog
  initial begin
    #50000;
    err_total++;
    tally_and_finish;
  end
  // ============================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h000, 32'hffff_ffff, 32'h1, 2'h0);
    rd(12'h004, 32'h9, 32'h9, 2'h0);
    rd(12'h010, 32'hffff_ffff, 32'h0, 2'h2);
    wr(12'h010, 32'h0, 2'h2);
    for (int i = 0; i < 16; i++) begin
      st = lfsr(st);
      snd(st, 2'h0, 2'h0, 2'h0, 1'b0);
      ex(3, 1'b1, 32'h003f_ffff, {16'h0, st});
    end
    snd(16'hbcbc, 2'h3, 2'h0, 2'h0, 1'b0);
    ex(3, 1'b1, 32'h003f_ffff, 32'h0003_bcbc);
    snd(16'h0, 2'h0, 2'h1, 2'h1, 1'b0);
    ex(2, 1'b0, 32'h3ff, 32'h18b);
    snd(16'h0, 2'h0, 2'h1, 2'h0, 1'b0);
    ex(2, 1'b0, 32'h3ff, 32'h274);
    $display("coder tests done");
    inj(20'h3e8fa);
    ex(1, 1'b1, 32'h0041_00ff, 32'h0041_00bc);
    inj(20'h3e8fa);
    ex(1, 1'b1, 32'h0014_0000, 32'h0014_0000);
    inj(20'h003ff);
    ex(1, 1'b1, 32'h0004_0000, 32'h0004_0000);
    wr(12'h000, 32'h41, 2'h0);
    @(posedge aclk);
    rx_revbitorder <= 1'b1;
    inj(20'h0017c);
    ex(1, 1'b1, 32'h0001_00ff, 32'h0001_00bc);
    @(posedge aclk);
    inj_en <= 1'b0;
    $display("decoder tests done");
    wr(12'h000, 32'h05, 2'h0);
    snd(16'hbcad, 2'h0, 2'h0, 2'h0, 1'b0);
    ex(3, 1'b1, 32'hffff, 32'h3db5);
    wr(12'h000, 32'h09, 2'h0);
    snd(16'hbcad, 2'h0, 2'h0, 2'h0, 1'b0);
    ex(3, 1'b1, 32'hffff, 32'h3db5);
    wr(12'h000, 32'h00, 2'h0);
    snd(16'hbcad, 2'h0, 2'h0, 2'h0, 1'b1);
    ex(2, 1'b0, 32'hfffff, {12'h0, 10'h343, 10'h352});
    snd(16'hbcad, 2'h0, 2'h0, 2'h0, 1'b0);
    ex(2, 1'b0, 32'hfffff, 32'h000f_0ad2);
    @(posedge aclk);
    tx_slipsel <= 5'h04;
    wr(12'h000, 32'h10, 2'h0);
    tx_slipsel <= 5'h00;
    snd(16'hbcad, 2'h0, 2'h0, 2'h0, 1'b0);
    ex(2, 1'b0, 32'h0003_fcff, 32'h0000_f4b5);
    wr(12'h000, 32'h30, 2'h0);
    snd(16'hbcad, 2'h0, 2'h0, 2'h0, 1'b0);
    ex(2, 1'b0, 32'h0003_fcff, 32'h0002_d43d);
    wr(12'h000, 32'h0b, 2'h0);
    snd(16'hbcad, 2'h0, 2'h0, 2'h0, 1'b1);
    ex(2, 1'b0, 32'hfffff, {12'h0, 10'h0bc, 10'h0ad});
    wr(12'h000, 32'h80, 2'h0);
    @(negedge aclk);
    chk({31'h0, tx_clk_shared}, 32'h1);
    $display("datapath tests done");
    rd(12'h008, 32'h3, 32'h3, 2'h0);
    chk({31'h0, irq}, 32'h0);
    wr(12'h00c, 32'h1, 2'h0);
    chk({31'h0, irq}, 32'h1);
    wr(12'h008, 32'h3, 2'h0);
    chk({31'h0, irq}, 32'h0);
    rd(12'h008, 32'h3, 32'h0, 2'h0);
    $display("interrupt tests done");
    repeat (5) @(posedge aclk);
    tally_and_finish;
  end
endmodule
